// >>> logic/nce_core.sv
// Purpose: fetch, decode and execute for a subset of a 4-bit core
// Assumes: program ROM and data RAM answer combinationally in the same cycle
// Notes:   opcodes outside the subset are skipped as no-ops, two-byte forms whole
`timescale 1ns/1ps
// How it works
// - call pushes the address after its two bytes, then jumps to the 12-bit target.
// - carry clear zeroes the carry flag and touches nothing else.
// - bcd adjust adds six and sets carry when acc above nine or carry set.
// - accumulator decrement subtracts one, carry untouched.
// - register decrement subtracts one from working register 0 to 4, carry untouched.
// - memory decrement via pair 1:0 or 3:2 subtracts one and writes back.
// - interrupt mask disables timer and external interrupts.
// - interrupt unmask enables timer and external interrupts.
// - two-byte halt stops the clock into power down, program counter advanced.
// - port read copies input port s or input port p into accumulator.
// - accumulator increment adds one, carry untouched.
// - register increment adds one to working register 0 to 4, carry untouched.
// - memory increment via pair 1:0 or 3:2 adds one and writes back.
module nce_core (
	input  wire logic                       ref_clk,
	input  wire logic                       rstn,
	output logic      [nce_pkg::PC_W-1:0]   rom_addr,
	input  wire logic [nce_pkg::OP_W-1:0]   rom_data,
	output logic      [nce_pkg::RAM_AW-1:0] ram_addr,
	input  wire logic [nce_pkg::NIB_W-1:0]  ram_rdata,
	output logic      [nce_pkg::NIB_W-1:0]  ram_wdata,
	output logic                            ram_we,
	input  wire logic [nce_pkg::NIB_W-1:0]  input_port_s,
	input  wire logic [nce_pkg::NIB_W-1:0]  input_port_p,
	output logic      [nce_pkg::NIB_W-1:0]  acc,
	output logic                            carry,
	output logic                            irq_enable,
	output logic      [nce_pkg::PC_W-1:0]   stack_top,
	output logic                            power_down
);
	import nce_pkg::*;

	// ************************************************************
	// state
	// ************************************************************
	nce_state_e           state;
	logic [PC_W-1:0]      pc;
	logic [OP_W-1:0]      first_op;
	logic                 mem_down;
	logic [NIB_W-1:0]     work_reg [NREG];
	logic [NIB_W-1:0]     port_s_meta;
	logic [NIB_W-1:0]     port_s_sync;
	logic [NIB_W-1:0]     port_p_meta;
	logic [NIB_W-1:0]     port_p_sync;
	logic [NIB_W-1:0]     mem_next;
	logic [2:0]           work_reg_sel;
	logic                 in_fetch;
	logic                 reg_op;

	// nibble step shared by accumulator and registers; wraps in 4 bits
	function automatic logic [NIB_W-1:0] nib_step(input logic [NIB_W-1:0] v, input logic dn);
		nib_step = dn ? v - 4'h1 : v + 4'h1;
	endfunction

	// an opcode that carries a second byte, so skipping stays aligned
	function automatic logic two_byte(input logic [OP_W-1:0] op);
		two_byte = op[7] || (op[7:4] == OP_IMM_HI) || (op == OP_HALT_1);
	endfunction

	assign rom_addr     = pc;
	assign in_fetch     = (state == NCE_FETCH);
	assign work_reg_sel = rom_data[3:1];
	assign reg_op       = in_fetch && (rom_data[7:4] == OP_REG_STEP_HI) && (work_reg_sel < 3'(NREG));
	assign power_down   = (state == NCE_HALTED);

	// ************************************************************
	// input port synchronisers
	// ************************************************************
	// ports come from pins; two flops each before the accumulator sees them
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			port_s_meta <= RST_NIB;
			port_s_sync <= RST_NIB;
			port_p_meta <= RST_NIB;
			port_p_sync <= RST_NIB;
		end else begin
			port_s_meta <= input_port_s;
			port_s_sync <= port_s_meta;
			port_p_meta <= input_port_p;
			port_p_sync <= port_p_meta;
		end
	end

	// ************************************************************
	// sequencer and program counter
	// ************************************************************
	// halt has no exit here: only reset leaves power down
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			state    <= NCE_FETCH;
			pc       <= RST_PC;
			first_op <= 8'h00;
		end else begin
			case (state)
				NCE_FETCH: begin
					first_op <= rom_data;
					pc       <= pc + PC_ONE;
					if (two_byte(rom_data)) begin
						state <= NCE_OPND;
					end else if (rom_data[7:2] == OP_MEM_INC_LO[7:2]) begin
						state <= NCE_MEM;
					end
				end
				NCE_OPND: begin
					state <= NCE_FETCH;
					if (first_op[7:4] == OP_CALL_HI) begin
						pc <= {first_op[3:0], rom_data};
					end else begin
						pc <= pc + PC_ONE;
						if (first_op == OP_HALT_1 && rom_data == OP_HALT_2) begin
							state <= NCE_HALTED;
						end
					end
				end
				NCE_MEM: begin
					state <= NCE_FETCH;
				end
				NCE_HALTED: begin
					state <= NCE_HALTED;
				end
				default: begin
					state <= NCE_FETCH;
				end
			endcase
		end
	end

	// ************************************************************
	// return stack, one level
	// ************************************************************
	// pc already points past the first byte, so one more gives pc+2
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			stack_top <= RST_PC;
		end else if (state == NCE_OPND && first_op[7:4] == OP_CALL_HI) begin
			stack_top <= pc + PC_ONE;
		end
	end

	// ************************************************************
	// accumulator and carry
	// ************************************************************
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			acc   <= RST_NIB;
			carry <= 1'b0;
		end else if (in_fetch) begin
			case (rom_data)
				OP_CARRY_CLEAR: carry <= 1'b0;
				OP_BCD_ADJUST: begin
					if (acc > BCD_MAX || carry) begin
						acc   <= acc + BCD_FIX;
						carry <= 1'b1;
					end
				end
				OP_ACC_DEC: acc <= nib_step(acc, 1'b1);
				OP_ACC_INC: acc <= nib_step(acc, 1'b0);
				OP_IN_S:    acc <= port_s_sync;
				OP_IN_P:    acc <= port_p_sync;
				default: begin
					acc <= acc;
				end
			endcase
		end
	end

	// ************************************************************
	// working registers
	// ************************************************************
	// selector codes 5 to 7 name no register and are ignored
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			for (int i = 0; i < NREG; i++) begin
				work_reg[i] <= RST_NIB;
			end
		end else if (reg_op) begin
			work_reg[work_reg_sel] <= nib_step(work_reg[work_reg_sel], rom_data[0]);
		end
	end

	// ************************************************************
	// interrupt enable
	// ************************************************************
	// one bit gates both the timer and external sources
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			irq_enable <= 1'b0;
		end else if (in_fetch && rom_data == OP_IRQ_MASK) begin
			irq_enable <= 1'b0;
		end else if (in_fetch && rom_data == OP_IRQ_UNMASK) begin
			irq_enable <= 1'b1;
		end
	end

	// ************************************************************
	// data memory read-modify-write
	// ************************************************************
	nce_nib_step u_mem_step (
		.value_in  (ram_rdata),
		.down      (mem_down),
		.value_out (mem_next)
	);

	// address is latched at fetch, data read the next cycle and written back the cycle after
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			ram_addr  <= 8'h00;
			mem_down  <= 1'b0;
			ram_wdata <= RST_NIB;
			ram_we    <= 1'b0;
		end else begin
			ram_we <= 1'b0;
			if (in_fetch && rom_data[7:2] == OP_MEM_INC_LO[7:2]) begin
				mem_down <= rom_data[0];
				if (rom_data[1]) begin
					ram_addr <= {work_reg[3], work_reg[2]};
				end else begin
					ram_addr <= {work_reg[1], work_reg[0]};
				end
			end
			if (state == NCE_MEM) begin
				ram_wdata <= mem_next;
				ram_we    <= 1'b1;
			end
		end
	end

endmodule // nce_core

// >>> logic/nce_nib_step.sv
// Purpose: plus or minus one on a nibble, wrapping modulo sixteen
// Assumes: purely combinational, same clock domain as its user
// Notes:   used for the data memory read-modify-write path
`timescale 1ns/1ps
module nce_nib_step (
	input  wire logic [nce_pkg::NIB_W-1:0] value_in,
	input  wire logic                      down,
	output logic      [nce_pkg::NIB_W-1:0] value_out
);
	import nce_pkg::*;

	// ************************************************************
	// step
	// ************************************************************
	// the 4-bit result drops the carry out, which gives the wrap
	always_comb begin
		if (down) begin
			value_out = value_in - 4'h1;
		end else begin
			value_out = value_in + 4'h1;
		end
	end

endmodule // nce_nib_step

// >>> logic/nce_pkg.sv
// Purpose: shared constants for the nibble core execute subset
// Assumes: 8-bit opcodes, 4-bit data path, 12-bit program counter
// Notes:   named opcode values and reset values live here only
package nce_pkg;

	// ************************************************************
	// widths
	// ************************************************************
	localparam int PC_W   = 12;
	localparam int NIB_W  = 4;
	localparam int OP_W   = 8;
	localparam int RAM_AW = 8;
	localparam int NREG   = 5;

	// ************************************************************
	// opcodes
	// ************************************************************
	localparam logic [OP_W-1:0]  OP_CARRY_CLEAR = 8'h2A;
	localparam logic [OP_W-1:0]  OP_BCD_ADJUST  = 8'h36;
	localparam logic [OP_W-1:0]  OP_ACC_DEC     = 8'h3F;
	localparam logic [OP_W-1:0]  OP_ACC_INC     = 8'h31;
	localparam logic [OP_W-1:0]  OP_IRQ_MASK    = 8'h2D;
	localparam logic [OP_W-1:0]  OP_IRQ_UNMASK  = 8'h2C;
	localparam logic [OP_W-1:0]  OP_IN_S        = 8'h33;
	localparam logic [OP_W-1:0]  OP_IN_P        = 8'h34;
	localparam logic [OP_W-1:0]  OP_HALT_1      = 8'h37;
	localparam logic [OP_W-1:0]  OP_HALT_2      = 8'h3E;
	localparam logic [OP_W-1:0]  OP_MEM_INC_LO  = 8'h0C;
	localparam logic [OP_W-1:0]  OP_MEM_DEC_LO  = 8'h0D;
	localparam logic [OP_W-1:0]  OP_MEM_INC_HI  = 8'h0E;
	localparam logic [OP_W-1:0]  OP_MEM_DEC_HI  = 8'h0F;
	localparam logic [3:0]       OP_CALL_HI     = 4'hF;
	localparam logic [3:0]       OP_REG_STEP_HI = 4'h1;
	localparam logic [3:0]       OP_IMM_HI      = 4'h4;

	// ************************************************************
	// arithmetic constants and reset values
	// ************************************************************
	localparam logic [NIB_W-1:0] BCD_MAX        = 4'h9;
	localparam logic [NIB_W-1:0] BCD_FIX        = 4'h6;
	localparam logic [NIB_W-1:0] RST_NIB        = 4'h0;
	localparam logic [PC_W-1:0]  RST_PC         = 12'h000;
	localparam logic [PC_W-1:0]  PC_ONE         = 12'h001;

	// ************************************************************
	// sequencer states
	// ************************************************************
	typedef enum logic [1:0] {
		NCE_FETCH,
		NCE_OPND,
		NCE_MEM,
		NCE_HALTED
	} nce_state_e;

endpackage

// >>> tb/nce_core_assertions.sv
// Purpose: temporal checks on the core ports
// Assumes: opcode bytes only count in fetch cycles
// Notes:   fetch is tracked by a shadow flag
`timescale 1ns/1ps
module nce_core_chk import nce_pkg::*; (
	input wire logic             ref_clk,
	input wire logic             rstn,
	input wire logic [PC_W-1:0]  rom_addr,
	input wire logic [OP_W-1:0]  rom_data,
	input wire logic [RAM_AW-1:0] ram_addr,
	input wire logic [NIB_W-1:0] ram_rdata,
	input wire logic [NIB_W-1:0] ram_wdata,
	input wire logic             ram_we,
	input wire logic [NIB_W-1:0] acc,
	input wire logic             carry,
	input wire logic             irq_enable,
	input wire logic [PC_W-1:0]  stack_top,
	input wire logic             power_down
);
	logic f;
	logic fe;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rstn);
	// operand and memory cycles carry no opcode, so they must not trigger checks
	always_ff @(posedge ref_clk or negedge rstn)
		if (!rstn) f <= 1'b1;
		else f <= !(fe && (rom_data[7] || rom_data[7:4] == OP_IMM_HI || rom_data == OP_HALT_1
			|| rom_data[7:2] == 6'h03));
	assign fe = f && !power_down;
	sequence s_call; fe && rom_data[7:4] == OP_CALL_HI ##1 1'b1; endsequence
	sequence s_halt; fe && rom_data == OP_HALT_1 ##1 rom_data == OP_HALT_2; endsequence
	sequence s_mem(bit dn); fe && rom_data[7:2] == 6'h03 && rom_data[0] == dn ##1 1'b1; endsequence
	a_carry_clear: assert property (fe && rom_data == OP_CARRY_CLEAR |=> !carry && acc == $past(acc))
		else $error("carry clear wrong");
	a_bcd_fix: assert property (fe && rom_data == OP_BCD_ADJUST && (acc > 4'h9 || carry)
		|=> carry && acc == $past(acc) + 4'h6) else $error("bcd fix wrong");
	a_bcd_keep: assert property (fe && rom_data == OP_BCD_ADJUST && acc <= 4'h9 && !carry
		|=> !carry && $stable(acc)) else $error("bcd keep wrong");
	a_acc_dec: assert property (fe && rom_data == OP_ACC_DEC |=> acc == $past(acc) - 4'h1 && $stable(carry))
		else $error("acc decrement wrong");
	a_acc_inc: assert property (fe && rom_data == OP_ACC_INC |=> acc == $past(acc) + 4'h1 && $stable(carry))
		else $error("acc increment wrong");
	a_irq_mask: assert property (fe && rom_data == OP_IRQ_MASK |=> !irq_enable)
		else $error("mask wrong");
	a_irq_unmask: assert property (fe && rom_data == OP_IRQ_UNMASK |=> irq_enable)
		else $error("unmask wrong");
	a_call_stack: assert property (s_call |=> stack_top == $past(rom_addr, 2) + 12'h002
		&& {OP_CALL_HI, rom_addr} == {$past(rom_data, 2), $past(rom_data)}) else $error("call wrong");
	a_halt_enter: assert property (s_halt |=> power_down && rom_addr == $past(rom_addr) + PC_ONE)
		else $error("halt entry wrong");
	a_halt_stays: assert property (power_down |=> power_down && $stable(rom_addr))
		else $error("halt left");
	a_mem_inc: assert property (s_mem(1'b0) |=> ram_we && ram_wdata == $past(ram_rdata) + 4'h1)
		else $error("memory increment wrong");
	a_mem_dec: assert property (s_mem(1'b1) |=> ram_we && ram_wdata == $past(ram_rdata) - 4'h1)
		else $error("memory decrement wrong");
	// the write must land where the read was taken, one cycle earlier
	a_write_addr_held: assert property (ram_we |-> $stable(ram_addr))
		else $error("write address moved");
endmodule // nce_core_chk
bind nce_core nce_core_chk u_chk (.ref_clk, .rstn, .rom_addr, .rom_data, .ram_addr, .ram_rdata, .ram_wdata, .ram_we,
	.acc, .carry, .irq_enable, .stack_top, .power_down);

// >>> tb/nce_mem_model.sv
// Purpose: program ROM and data RAM seen by the core
// Assumes: both answer combinationally, RAM writes on the rising edge
// Notes:   the bench fills both arrays before releasing reset
`timescale 1ns/1ps
module nce_mem_model (
	input  wire logic [nce_pkg::PC_W-1:0]   rom_addr,
	output logic      [nce_pkg::OP_W-1:0]   rom_data,
	input  wire logic                       ref_clk,
	input  wire logic [nce_pkg::RAM_AW-1:0] ram_addr,
	output logic      [nce_pkg::NIB_W-1:0]  ram_rdata,
	input  wire logic [nce_pkg::NIB_W-1:0]  ram_wdata,
	input  wire logic                       ram_we
);
	import nce_pkg::*;
	logic [OP_W-1:0]  rom [2**PC_W];
	logic [NIB_W-1:0] ram [2**RAM_AW];
	// no wait states: the core expects the byte in the same cycle
	assign rom_data  = rom[rom_addr];
	assign ram_rdata = ram[ram_addr];
	always @(posedge ref_clk) if (ram_we) ram[ram_addr] <= ram_wdata;
endmodule // nce_mem_model

// >>> tb/nibble_core_exec_subset_bench.sv
// Purpose: random programs run on the core against an integer model
// Assumes: first two bytes, a halt with a wrong second byte, pass while the port synchronisers settle
// Notes:   each run ends in a call, then a halt, then the state is compared
`timescale 1ns/1ps
`define CHK(x, y) begin num_checks++; if ((x) !== (y)) begin n_fail++; $display("BAD %0t mismatch", $time); end end
module nibble_core_exec_subset_bench;
	import nce_pkg::*;
	logic             ref_clk = 1'b0;
	logic             rstn = 1'b0;
	logic [NIB_W-1:0] input_port_s = 4'h0;
	logic [NIB_W-1:0] input_port_p = 4'h0;
	wire  [PC_W-1:0]  rom_addr, stack_top;
	wire  [OP_W-1:0]  rom_data;
	wire  [RAM_AW-1:0] ram_addr;
	wire  [NIB_W-1:0] ram_rdata, ram_wdata, acc;
	wire              ram_we, carry, irq_enable, power_down;
	int n_fail = 0, num_checks = 0, seed = 32'h8a517d72;
	int a, c, ie, op, k, r[5], m[256];
	logic [PC_W-1:0] tgt;
	// the last two select codes 5 and 7, which name no register and must change nothing
	int ops[24] = '{8'h2A, 8'h36, 8'h3F, 8'h31, 8'h2D, 8'h2C, 8'h33, 8'h34, 8'h0C, 8'h0D, 8'h0E,
		8'h0F, 8'h10, 8'h11, 8'h12, 8'h13, 8'h14, 8'h15, 8'h16, 8'h17, 8'h18, 8'h19, 8'h1B, 8'h1E};
	always #5 ref_clk = ~ref_clk;
	nce_core dut (.ref_clk, .rstn, .rom_addr, .rom_data, .ram_addr, .ram_rdata, .ram_wdata, .ram_we,
		.input_port_s, .input_port_p, .acc, .carry, .irq_enable, .stack_top, .power_down);
	nce_mem_model mem (.rom_addr, .rom_data, .ref_clk, .ram_addr, .ram_rdata, .ram_wdata, .ram_we);
	// reference model of one opcode, plain integers wrapping by modulo
	task automatic exec(input int o);
		int ad, n;
		ad = (o & 2) ? r[3] * 16 + r[2] : r[1] * 16 + r[0];
		n = (o >> 1) & 7;
		case (o)
			8'h2A: c = 0;
			8'h36: if (a > 9 || c) begin a = (a + 6) % 16; c = 1; end
			8'h3F: a = (a + 15) % 16;
			8'h31: a = (a + 1) % 16;
			8'h2D: ie = 0;
			8'h2C: ie = 1;
			8'h33: a = input_port_s;
			8'h34: a = input_port_p;
			8'h0C, 8'h0E: m[ad] = (m[ad] + 1) % 16;
			8'h0D, 8'h0F: m[ad] = (m[ad] + 15) % 16;
			default: if (n < NREG) r[n] = (r[n] + ((o & 1) ? 15 : 1)) % 16;
		endcase
	endtask
	task automatic test_done;
		$display("checks %0d mismatches %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	// every run after the first re-enters reset mid-halt, so the async clear is exercised each time
	initial begin
		for (int run = 0; run < 12; run++) begin
			@(negedge ref_clk);
			rstn = 1'b0;
			input_port_s = 4'($random(seed));
			input_port_p = 4'($random(seed));
			a = 0; c = 0; ie = 0;
			foreach (r[i]) r[i] = 0;
			foreach (mem.rom[i]) mem.rom[i] = 8'h00;
			mem.rom[0] = OP_HALT_1;
			foreach (m[i]) begin m[i] = {$random(seed)} % 16; mem.ram[i] = 4'(m[i]); end
			for (int i = 2; i < 26; i++) begin op = ops[{$random(seed)} % 24]; mem.rom[i] = 8'(op); exec(op); end
			tgt = 12'h800 + 12'(run * 37);
			mem.rom[26] = {OP_CALL_HI, tgt[11:8]};
			mem.rom[27] = tgt[7:0];
			mem.rom[tgt] = OP_HALT_1;
			mem.rom[tgt + 1] = OP_HALT_2;
			repeat (16) @(negedge ref_clk);
			rstn = 1'b1;
			for (k = 0; k < 300 && power_down !== 1'b1; k++) @(negedge ref_clk);
			`CHK(power_down, 1'b1)
			if (k == 300) test_done;
			`CHK(rom_addr, tgt + 12'h002)
			`CHK(stack_top, 12'h01C)
			`CHK(acc, 4'(a))
			`CHK(carry, 1'(c))
			`CHK(irq_enable, 1'(ie))
			foreach (r[i]) `CHK(dut.work_reg[i], 4'(r[i]))
			foreach (m[i]) `CHK(mem.ram[i], 4'(m[i]))
			$display("run %0d done", run);
		end
		test_done;
	end
endmodule // nibble_core_exec_subset_bench
